// ===== memport_top.sv
// asynchronous external memory port: switch, phase sequencer, pins
// assumes config stable between accesses; wait_in is an async pin
`timescale 1ns/10ps
`default_nettype none
module memport_top
    import memport_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // ========== requesters
    input wire logic dma_req,
    input wire logic dma_write,
    input wire logic [31:0] dma_addr,
    input wire logic [DATA_W-1:0] dma_wdata,
    input wire logic core_req,
    input wire logic core_write,
    input wire logic [31:0] core_addr,
    input wire logic [DATA_W-1:0] core_wdata,
    output logic dma_done,
    output logic core_done,
    output logic [DATA_W-1:0] read_data,
    // ========== configuration and busy status
    input wire logic [1:0] dma_priority,
    input wire logic [1:0] core_priority,
    input wire logic [REGIONS-1:0] select_strobe_mode,
    input wire logic [REGIONS-1:0] extended_wait_enable,
    input wire logic [REGIONS-1:0] wide_bus,
    input wire logic wait_polarity,
    input wire logic [SETUP_W-1:0] read_setup,
    input wire logic [STROBE_W-1:0] read_strobe,
    input wire logic [HOLD_W-1:0] read_hold,
    input wire logic [SETUP_W-1:0] write_setup,
    input wire logic [STROBE_W-1:0] write_strobe,
    input wire logic [HOLD_W-1:0] write_hold,
    input wire logic [TA_W-1:0] turnaround,
    output logic busy,
    // ========== pins
    output logic [WORD_ADDR_W-1:0] word_address_out,
    output logic [BANK_W-1:0] bank_address_out,
    output logic [REGIONS-1:0] region_select_n,
    output logic read_write_select,
    output logic output_enable_n,
    output logic write_enable_n,
    input wire logic [DATA_W-1:0] ext_data_bus_in,
    output logic [DATA_W-1:0] ext_data_bus_out,
    output logic ext_data_bus_oe,
    input wire logic wait_in
);
    // ==========
    // port clock: enable tick every sixth system clock
    logic [2:0] div_reg;
    wire tick = ce && (div_reg == DIV_LAST);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_reg <= 3'h0;
        end else if (ce) begin
            div_reg <= (div_reg == DIV_LAST) ? 3'h0 : div_reg + 3'h1;
        end
    end

    // ==========
    // wait synchroniser; first stage feeds only the second
    logic wait_meta_reg;
    logic wait_sync_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wait_meta_reg <= 1'b0;
            wait_sync_reg <= 1'b0;
        end else if (ce) begin
            wait_meta_reg <= wait_in;
            wait_sync_reg <= wait_meta_reg;
        end
    end
    wire wait_active = (wait_sync_reg == wait_polarity);

    // ==========
    // request switch
    phase_type phase_reg;
    phase_type phase_next;
    logic grant_dma;
    logic grant_core;
    logic start_reg;
    // free only between grants so a grant never overlaps an access
    wire port_free = (phase_reg == st_idle) && !start_reg &&
        !grant_dma && !grant_core;

    memport_arbiter arb (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .port_free(port_free),
        .dma_req(dma_req && !dma_done),
        .core_req(core_req && !core_done),
        .dma_prio(dma_priority),
        .core_prio(core_priority),
        .grant_dma(grant_dma),
        .grant_core(grant_core)
    );

    // ==========
    // latched access
    logic owner_dma_reg;
    logic write_reg;
    logic [31:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    wire got = grant_dma || grant_core;
    wire [31:0] sel_addr = grant_dma ? dma_addr : core_addr;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            owner_dma_reg <= 1'b0;
            write_reg <= 1'b0;
            addr_reg <= 32'h0;
            wdata_reg <= '0;
            start_reg <= 1'b0;
        end else if (ce) begin
            if (got) begin
                owner_dma_reg <= grant_dma;
                write_reg <= grant_dma ? dma_write : core_write;
                addr_reg <= sel_addr;
                wdata_reg <= grant_dma ? dma_wdata : core_wdata;
            end
            start_reg <= got || (start_reg && !tick);
        end
    end

    // region from bits above the 32MB window
    wire [1:0] region = addr_reg[REGION_BYTE_W+1:REGION_BYTE_W];
    wire wide = wide_bus[region];
    wire ss_mode = select_strobe_mode[region];
    wire ew_on = extended_wait_enable[region];
    // word address in bits 2 up; bank lines give bits 1:0, or bits 1 and 24 when wide
    wire [WORD_ADDR_W-1:0] waddr = addr_reg[WORD_ADDR_W+1:2];
    wire [BANK_W-1:0] baddr = wide ? {addr_reg[1], addr_reg[24]} :
        addr_reg[1:0];

    // ==========
    // phase sequencer
    wire tmr_done;
    logic tmr_load;
    logic [STROBE_W-1:0] tmr_val;
    wire [STROBE_W-1:0] setup_len = STROBE_W'(write_reg ? write_setup :
        read_setup);
    wire [STROBE_W-1:0] strobe_len = write_reg ? write_strobe : read_strobe;
    wire [STROBE_W-1:0] hold_len = STROBE_W'(write_reg ? write_hold :
        read_hold);
    wire strobe_held = ew_on && wait_active;

    always_comb begin
        phase_next = phase_reg;
        tmr_load = 1'b0;
        tmr_val = '0;
        case (phase_reg)
            st_idle: begin
                if (start_reg && tick) begin
                    phase_next = st_setup;
                    tmr_load = 1'b1;
                    tmr_val = setup_len;
                end
            end
            st_setup: begin
                if (tick && tmr_done) begin
                    phase_next = st_strobe;
                    tmr_load = 1'b1;
                    tmr_val = strobe_len;
                end
            end
            st_strobe: begin
                if (tick && tmr_done && !strobe_held) begin
                    phase_next = st_hold;
                    tmr_load = 1'b1;
                    tmr_val = hold_len;
                end
            end
            st_hold: begin
                if (tick && tmr_done) begin
                    phase_next = st_turn;
                    tmr_load = 1'b1;
                    tmr_val = STROBE_W'(turnaround);
                end
            end
            st_turn: begin
                if (tick && tmr_done) begin
                    phase_next = st_idle;
                end
            end
            default: phase_next = st_idle;
        endcase
    end

    memport_timer tmr (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .tick(tick),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    wire in_access = (phase_reg == st_setup) || (phase_reg == st_strobe) ||
        (phase_reg == st_hold);
    wire in_strobe = (phase_reg == st_strobe);
    wire select_on = ss_mode ? in_strobe : in_access;
    wire finish = (phase_reg == st_hold) && (phase_next == st_turn);
    // sample at strobe end; the part releases the bus once oe_n rises
    wire strobe_end = in_strobe && (phase_next == st_hold);
    wire [REGIONS-1:0] sel_n_next = select_on ?
        ~(4'h1 << region) : SEL_IDLE;
    // byte lane picks the low lane in 8-bit mode
    wire [DATA_W-1:0] rd_word = wide ? ext_data_bus_in :
        {8'h00, ext_data_bus_in[7:0]};

    // ==========
    // pins, all registered
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase_reg <= st_idle;
            region_select_n <= SEL_IDLE;
            output_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            read_write_select <= 1'b1;
            word_address_out <= '0;
            bank_address_out <= '0;
            ext_data_bus_out <= '0;
            ext_data_bus_oe <= 1'b0;
            read_data <= '0;
            dma_done <= 1'b0;
            core_done <= 1'b0;
            busy <= 1'b0;
        end else if (ce) begin
            phase_reg <= phase_next;
            region_select_n <= sel_n_next;
            output_enable_n <= !(in_strobe && !write_reg);
            write_enable_n <= !(in_strobe && write_reg);
            read_write_select <= in_access ? !write_reg : 1'b1;
            word_address_out <= waddr;
            bank_address_out <= baddr;
            ext_data_bus_out <= wdata_reg;
            ext_data_bus_oe <= in_access && write_reg;
            if (strobe_end && !write_reg) begin
                read_data <= rd_word;
            end
            dma_done <= finish && owner_dma_reg;
            core_done <= finish && !owner_dma_reg;
            busy <= phase_next != st_idle || start_reg || got;
        end
    end

    a_idle_inactive: assert property (@(posedge clk_sys) disable iff (rst)
        $past(phase_reg) == st_idle && $past(ce) |->
        region_select_n == SEL_IDLE && output_enable_n &&
        write_enable_n) else $error("strobe active while idle");
    a_oe_read_only: assert property (@(posedge clk_sys) disable iff (rst)
        !output_enable_n |-> read_write_select) else
        $error("output enable during write");
    a_we_write_only: assert property (@(posedge clk_sys) disable iff (rst)
        !write_enable_n |-> !read_write_select && output_enable_n) else
        $error("write enable during read");
    a_div_tick: assert property (@(posedge clk_sys) disable iff (rst)
        tick |=> !tick [*5]) else $error("tick spacing wrong");
    a_wait_holds: assert property (@(posedge clk_sys) disable iff (rst)
        ce && in_strobe && strobe_held |=> phase_reg == st_strobe) else
        $error("strobe left under wait");
    a_ss_select: assert property (@(posedge clk_sys) disable iff (rst)
        ce && ss_mode && phase_reg == st_setup |=>
        region_select_n == SEL_IDLE) else
        $error("select during setup in strobe mode");
    a_one_done: assert property (@(posedge clk_sys) disable iff (rst)
        !(dma_done && core_done)) else $error("two completions");
    a_setup_first: assert property (@(posedge clk_sys) disable iff (rst)
        ce && phase_reg == st_idle && phase_next == st_setup |=>
        output_enable_n && write_enable_n) else
        $error("strobe without setup");
endmodule
`default_nettype wire

// ===== memport_pkg.sv
// constants, types and priority defaults for the external memory port
// assumes one system clock; configuration arrives as plain ports
//
// How it works
// - one internal request is served to completion before the next
// - simultaneous requests: the higher-priority source goes first
// - after each completion all pending requests are judged again
// - each source has a programmable priority; dma outranks core by default
// - port state advances on one enable tick per six system clocks
// - external address is word address plus two bank address lines
// - four chip-select regions of up to 32MB each
// - bidirectional data bus used at 8 or 16 bits wide
// - each region select is active low toward its device
// - read/write select high through reads, low through writes
// - output enable low only in the strobe phase of a read
// - write enable low only in the strobe phase of a write
// - with extended wait on, asserted wait holds the strobe phase
// - wait active level chosen by a polarity bit
// - setup, strobe, hold and turnaround lengths are programmable
// - lengths count port clock cycles; setup, strobe and hold separate for reads and writes, one shared turnaround
// - select-strobe mode: select only in strobe; normal: whole access
// - setup runs from address valid until the strobe goes active
package memport_pkg;
    localparam int REGIONS = 4;
    localparam int WORD_ADDR_W = 22;
    localparam int BANK_W = 2;
    // 32MB per region in bytes needs 25 address bits
    localparam int REGION_BYTE_W = 25;
    localparam int DATA_W = 16;
    localparam int SETUP_W = 4;
    localparam int STROBE_W = 6;
    localparam int HOLD_W = 3;
    localparam int TA_W = 2;
    localparam int CLK_DIV = 6;
    localparam logic [2:0] DIV_LAST = 3'h5;
    localparam logic [1:0] PRIO_DMA_RESET = 2'h0;
    localparam logic [1:0] PRIO_CORE_RESET = 2'h1;
    localparam logic [REGIONS-1:0] SEL_IDLE = 4'hF;

    typedef enum logic [2:0] {
        st_idle, st_setup, st_strobe, st_hold, st_turn
    } phase_type;
endpackage

// ===== memport_arbiter.sv
// two-source request switch with programmable priorities
// assumes requests stay raised until granted and port busy is same-clock
`timescale 1ns/10ps
`default_nettype none
module memport_arbiter
    import memport_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic port_free,
    input wire logic dma_req,
    input wire logic core_req,
    input wire logic [1:0] dma_prio,
    input wire logic [1:0] core_prio,
    output logic grant_dma,
    output logic grant_core
);
    // lower value ranks higher; tie goes to dma
    wire dma_wins = (dma_prio <= core_prio);
    wire pick_dma = dma_req && (dma_wins || !core_req);
    wire pick_core = core_req && !pick_dma;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            grant_dma <= 1'b0;
            grant_core <= 1'b0;
        end else if (ce) begin
            // fresh choice every time the port frees up
            grant_dma <= port_free && pick_dma;
            grant_core <= port_free && pick_core;
        end
    end

    a_single_grant: assert property (@(posedge clk_sys) disable iff (rst)
        !(grant_dma && grant_core)) else $error("two grants");
    a_prio_order: assert property (@(posedge clk_sys) disable iff (rst)
        ce && port_free && dma_req && core_req && dma_prio < core_prio
        |=> grant_dma) else $error("priority ignored");
endmodule
`default_nettype wire

// ===== memport_timer.sv
// phase length down counter, loaded per phase
// assumes load and tick come from the same clock
`timescale 1ns/10ps
`default_nettype none
module memport_timer
    import memport_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic tick,
    input wire logic load,
    input wire logic [STROBE_W-1:0] load_val,
    output logic done
);
    logic [STROBE_W-1:0] count_reg;
    wire [STROBE_W-1:0] count_next = load ? load_val :
        (count_reg != '0 ? count_reg - 1'b1 : count_reg);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (ce && (tick || load)) begin
            count_reg <= count_next;
        end
    end
    assign done = (count_reg == '0);
endmodule
`default_nettype wire

// ===== memport_sram_model.sv
// sram stand-in for the memory port, with optional wait stretching
// assumes one system clock and the port's pins as its inputs
`timescale 1ns/10ps
`default_nettype none
module memport_sram_model
    import memport_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [WORD_ADDR_W-1:0] word_address_out,
    input wire logic [BANK_W-1:0] bank_address_out,
    input wire logic [REGIONS-1:0] region_select_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic [DATA_W-1:0] ext_data_bus_out,
    input wire logic wait_level,
    input wire logic [7:0] stall,
    output logic [DATA_W-1:0] ext_data_bus_in,
    output logic wait_in
);
    // ====
    // storage
    logic [DATA_W-1:0] mem [256];
    logic [DATA_W-1:0] last_reg = 16'h0000;
    logic [7:0] strobe_reg = 8'h00;
    wire logic [7:0] key = {word_address_out[5:0], bank_address_out};
    wire logic sel = region_select_n != SEL_IDLE;
    wire logic rd = sel && !output_enable_n;
    wire logic strobe = !(output_enable_n && write_enable_n);
    // released bus inverts, so a stale value never reads as good
    assign ext_data_bus_in = rd ? mem[key] : ~last_reg;
    // slow part: wait held over the first stall clocks of a strobe
    assign wait_in = (strobe && strobe_reg < stall) ?
        wait_level : ~wait_level;
    always @(posedge clk_sys) begin
        strobe_reg <= strobe ? strobe_reg + 8'h01 : 8'h00;
        if (rd) begin
            last_reg <= mem[key];
        end
        if (sel && !write_enable_n) begin
            mem[key] <= ext_data_bus_out;
        end
    end
endmodule
`default_nettype wire

// ===== memport_tb.sv
// self-checking bench for the external memory port
// assumes the design files and the sram model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb
    import memport_pkg::*;
;
    typedef struct {logic s; logic w; logic [31:0] a; logic [15:0] d;} row_type;
    logic clk_sys, rst, ce = 1'b1;
    logic dma_req = 1'b0, dma_write = 1'b0, core_req = 1'b0;
    logic core_write = 1'b0, dma_done, core_done, busy, wait_in;
    logic [31:0] dma_addr = '0, core_addr = '0;
    logic [DATA_W-1:0] dma_wdata = '0, core_wdata = '0, read_data;
    logic [DATA_W-1:0] ext_data_bus_in, ext_data_bus_out;
    logic [1:0] dma_priority = PRIO_DMA_RESET;
    logic [1:0] core_priority = PRIO_CORE_RESET;
    logic [REGIONS-1:0] select_strobe_mode = 4'h8, wide_bus = 4'hB;
    logic [REGIONS-1:0] extended_wait_enable = 4'h0, region_select_n, sel_or;
    logic [SETUP_W-1:0] read_setup = 4'h1, write_setup = 4'h2;
    logic [STROBE_W-1:0] read_strobe = 6'h02, write_strobe = 6'h01;
    logic [HOLD_W-1:0] read_hold = 3'h0, write_hold = 3'h1;
    logic [TA_W-1:0] turnaround = 2'h1;
    logic [WORD_ADDR_W-1:0] word_address_out;
    logic [BANK_W-1:0] bank_address_out;
    logic read_write_select, output_enable_n, write_enable_n, rw_bad, cur_wr;
    logic ext_data_bus_oe, wait_polarity = 1'b0, wait_level = 1'b0;
    logic [7:0] stall = 8'h00;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    int oe_cnt, we_cnt, sel_cnt, setup_cnt;
    row_type rows [8] = '{
        '{1'b0, 1'b1, 32'h0000_0010, 16'hA5C3},
        '{1'b1, 1'b1, 32'h0200_0014, 16'h1234},
        '{1'b0, 1'b1, 32'h0400_0019, 16'h5ABE},
        '{1'b1, 1'b1, 32'h0600_001E, 16'h7E81},
        '{1'b1, 1'b0, 32'h0000_0010, 16'hA5C3},
        '{1'b0, 1'b0, 32'h0200_0014, 16'h1234},
        '{1'b1, 1'b0, 32'h0400_0019, 16'h5ABE},
        '{1'b0, 1'b0, 32'h0600_001E, 16'h7E81}
    };
    memport_top uut (
        .clk_sys, .rst, .ce, .dma_req, .dma_write, .dma_addr, .dma_wdata,
        .core_req, .core_write, .core_addr, .core_wdata, .dma_done,
        .core_done, .read_data, .dma_priority, .core_priority,
        .select_strobe_mode, .extended_wait_enable, .wide_bus,
        .wait_polarity, .read_setup, .read_strobe, .read_hold, .write_setup,
        .write_strobe, .write_hold, .turnaround, .busy, .word_address_out,
        .bank_address_out, .region_select_n, .read_write_select,
        .output_enable_n, .write_enable_n, .ext_data_bus_in,
        .ext_data_bus_out, .ext_data_bus_oe, .wait_in
    );
    memport_sram_model mem_model (
        .clk_sys, .word_address_out, .bank_address_out, .region_select_n,
        .output_enable_n, .write_enable_n, .ext_data_bus_out, .wait_level,
        .stall, .ext_data_bus_in, .wait_in
    );
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // ====
    // pin monitor, counts clocks per access
    always @(posedge clk_sys) begin
        cycles++;
        if (!rst) begin
            if (region_select_n != SEL_IDLE && oe_cnt + we_cnt == 0 &&
                output_enable_n && write_enable_n) setup_cnt++;
            if (!output_enable_n) oe_cnt++;
            if (!write_enable_n) we_cnt++;
            if (region_select_n != SEL_IDLE) sel_cnt++;
            sel_or |= ~region_select_n;
            if (region_select_n != SEL_IDLE &&
                read_write_select !== !cur_wr) rw_bad = 1'b1;
        end
        if (cycles == 8000) begin
            check(0, 1, "cycle ceiling");
            close_out();
        end
    end
    // ====
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // done of the other source meanwhile means the wrong source was served
    task automatic wait_done(input logic s);
        int n;
        logic wrong;
        n = 0;
        wrong = 1'b0;
        do begin
            @(posedge clk_sys);
            n++;
            if ((s ? dma_done : core_done) === 1'b1) wrong = 1'b1;
        end while ((s ? core_done : dma_done) !== 1'b1 && n < 400);
        check(n < 400, 1'b1, "done in time");
        check(wrong, 1'b0, "other source done");
        #1;
    endtask
    task automatic xfer(input logic s, input logic w, input logic [31:0] a,
                        input logic [15:0] d);
        int es, eu, eh;
        logic [1:0] r;
        r = a[26:25];
        es = ((w ? write_strobe : read_strobe) + 1) * CLK_DIV;
        eu = ((w ? write_setup : read_setup) + 1) * CLK_DIV;
        eh = ((w ? write_hold : read_hold) + 1) * CLK_DIV;
        {oe_cnt, we_cnt, sel_cnt, setup_cnt} = '0;
        {sel_or, rw_bad, cur_wr} = {4'h0, 1'b0, w};
        {dma_write, dma_addr, dma_wdata} = {w, a, d};
        {core_write, core_addr, core_wdata} = {w, a, d};
        dma_req = !s;
        core_req = s;
        wait_done(s);
        dma_req = 1'b0;
        core_req = 1'b0;
        check(sel_or, 4'h1 << r, "region select");
        check(rw_bad, 1'b0, "rw level");
        check(w ? oe_cnt : we_cnt, 0, "unused strobe");
        if (extended_wait_enable[r] && stall != 0)
            check(oe_cnt + we_cnt > stall, 1'b1, "held by wait");
        else
            check(oe_cnt + we_cnt, es, "strobe length");
        if (select_strobe_mode[r]) begin
            check(sel_cnt, oe_cnt + we_cnt, "select in strobe");
            check(setup_cnt, 0, "select in setup");
        end else begin
            check(sel_cnt, eu + oe_cnt + we_cnt + eh, "select span");
            check(setup_cnt, eu, "setup length");
        end
        if (!w)
            check(read_data, wide_bus[r] ? d : {8'h00, d[7:0]}, "rdata");
    endtask
    // both raised together; the loser must still be served afterwards
    task automatic race(input logic [1:0] pd, input logic [1:0] pc,
                        input logic ec);
        {dma_priority, core_priority} = {pd, pc};
        {dma_write, dma_addr} = {1'b0, 32'h0000_0010};
        {core_write, core_addr} = {1'b0, 32'h0200_0014};
        dma_req = 1'b1;
        core_req = 1'b1;
        wait_done(ec);
        if (ec) core_req = 1'b0;
        else dma_req = 1'b0;
        wait_done(!ec);
        dma_req = 1'b0;
        core_req = 1'b0;
    endtask
    // ====
    // main sequence
    initial begin
        rst = 1'b1;
        repeat (8) @(posedge clk_sys);
        check(region_select_n, SEL_IDLE, "reset selects");
        check({output_enable_n, write_enable_n}, 2'h3, "reset strobes");
        #1;
        rst = 1'b0;
        $display("test reset done");
        for (int t = 0; t < 2; t++) begin
            foreach (rows[i]) xfer(rows[i].s, rows[i].w, rows[i].a, rows[i].d);
            $display("test table pass %0d done", t);
            // second pass: zero setup reads, zero strobe writes
            {read_setup, read_strobe, read_hold} = {4'h0, 6'h05, 3'h3};
            {write_setup, write_strobe, write_hold} = {4'h3, 6'h00, 3'h2};
            {turnaround, select_strobe_mode} = {2'h3, 4'h3};
        end
        race(2'h0, 2'h1, 1'b0);
        race(2'h1, 2'h0, 1'b1);
        race(2'h2, 2'h2, 1'b0);
        race(2'h3, 2'h2, 1'b1);
        $display("test priority done");
        {extended_wait_enable, stall} = {4'hF, 8'h3C};
        xfer(1'b0, 1'b0, 32'h0000_0010, 16'hA5C3);
        {wait_polarity, wait_level} = 2'h3;
        xfer(1'b1, 1'b1, 32'h0600_001E, 16'h0F0F);
        xfer(1'b0, 1'b0, 32'h0600_001E, 16'h0F0F);
        extended_wait_enable = 4'h0;
        xfer(1'b1, 1'b0, 32'h0600_001E, 16'h0F0F);
        check(region_select_n, SEL_IDLE, "idle selects");
        $display("test wait done");
        rst = 1'b1;
        @(posedge clk_sys);
        #1;
        rst = 1'b0;
        ce = 1'b0;
        dma_req = 1'b1;
        repeat (20) @(posedge clk_sys);
        check(busy, 1'b0, "frozen by enable");
        #1;
        ce = 1'b1;
        xfer(1'b0, 1'b0, 32'h0600_001E, 16'h0F0F);
        $display("test reset and enable done");
        close_out();
    end
endmodule
`default_nettype wire
